// [hw/srw_map.svh]
/*
  Register offsets, reset values and timing figures of the supervisor.
  Assumes a 100 MHz pclk and a 12-bit APB byte address.
*/
`ifndef SRW_MAP_SVH
`define SRW_MAP_SVH

`define SRW_ADDR_W        12
`define SRW_OFF_CTRL      12'h000
`define SRW_OFF_STATUS    12'h004
`define SRW_OFF_INT_STAT  12'h008
`define SRW_OFF_INT_MASK  12'h00C

`define SRW_CTRL_W        4
`define SRW_CTRL_RST      4'hD
`define SRW_IRQ_W         6
`define SRW_TMR_W         28

`define SRW_CLK_HZ        100000000
`define SRW_CYC_PER_MS    (`SRW_CLK_HZ / 1000)
`define SRW_CYC_PER_US    (`SRW_CLK_HZ / 1000000)
`define SRW_CLK_PERIOD_NS 10

`define SRW_NVM_WC_TYP_MS 5
`define SRW_NVM_WC_MAX_MS 10
`define SRW_POR_T0_MS     50
`define SRW_POR_T1_MS     200
`define SRW_POR_T2_MS     400
`define SRW_POR_T3_MS     800
`define SRW_WDT_T0_S      1.4
`define SRW_WDT_T1_MS     200
`define SRW_WDT_T2_MS     25
`define SRW_HOLD_LONG_MS  200
`define SRW_HOLD_SHORT_MS 25

`define SRW_MAN_QUAL_US   5
`define SRW_MAN_QUAL_CYC  (`SRW_MAN_QUAL_US * `SRW_CYC_PER_US)
`define SRW_MAN_CNT_W     10
`define SRW_LR_NS         500
`define SRW_LR_CYC        (`SRW_LR_NS / `SRW_CLK_PERIOD_NS)

`endif

// [hw/srw_pkg.sv]
/*
  Types of the supervisor: control word, interrupt bits, states.
  Assumes srw_map.svh supplies the widths.
*/
`include "srw_map.svh"

package srw_pkg;

  typedef struct packed {
    logic wdt_period_sel_hi;
    logic wdt_period_sel_lo;
    logic por_delay_sel_hi;
    logic por_delay_sel_lo;
  } srw_ctrl_t;

  typedef struct packed {
    logic nvm_done;
    logic third_fail;
    logic second_fail;
    logic supply_low;
    logic manual_reset;
    logic wdt_timeout;
  } srw_irq_t;

  typedef enum logic [2:0] {
    SRW_ST_LOW    = 3'b000,
    SRW_ST_POR    = 3'b001,
    SRW_ST_RUN    = 3'b010,
    SRW_ST_MANUAL = 3'b011,
    SRW_ST_WDT    = 3'b100
  } srw_state_t;

  typedef enum logic [2:0] {
    SRW_REG_CTRL   = 3'b000,
    SRW_REG_STATUS = 3'b001,
    SRW_REG_ISTAT  = 3'b010,
    SRW_REG_IMASK  = 3'b011,
    SRW_REG_NONE   = 3'b100
  } srw_reg_t;

endpackage

// [hw/srw_sync.sv]
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes inputs are asynchronous to pclk; resets to zero.
*/
`timescale 1ns/1ps

module srw_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// [hw/srw_timer.sv]
/*
  Down counter: load takes len, run decrements, expire on last tick.
  Assumes len is nonzero; load wins over run.
*/
`timescale 1ns/1ps
`include "srw_map.svh"

module srw_timer (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  load,
  input  wire logic                  run,
  input  wire logic [`SRW_TMR_W-1:0] len,
  output logic                       expire,
  output logic                       busy
);

  logic [`SRW_TMR_W-1:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= len;
    end else if (run && cnt != '0) begin
      cnt <= cnt - `SRW_TMR_W'(1);
    end
  end

  assign expire = run && !load && cnt == `SRW_TMR_W'(1);
  assign busy   = cnt != '0;

endmodule

// [hw/srw_supervisor.sv]
/*
  Supply supervisor with watchdog, manual reset and nonvolatile write
  timing, reached over APB.
  Assumes supply comparator and pin inputs are asynchronous; the write
  stop strobe comes from serial logic on pclk.
*/
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "srw_map.svh"

module srw_supervisor #(
  parameter logic [`SRW_TMR_W-1:0] POR_CYC_0 =
    `SRW_TMR_W'(`SRW_POR_T0_MS * `SRW_CYC_PER_MS),
  parameter logic [`SRW_TMR_W-1:0] POR_CYC_1 =
    `SRW_TMR_W'(`SRW_POR_T1_MS * `SRW_CYC_PER_MS),
  parameter logic [`SRW_TMR_W-1:0] POR_CYC_2 =
    `SRW_TMR_W'(`SRW_POR_T2_MS * `SRW_CYC_PER_MS),
  parameter logic [`SRW_TMR_W-1:0] POR_CYC_3 =
    `SRW_TMR_W'(`SRW_POR_T3_MS * `SRW_CYC_PER_MS),
  parameter logic [`SRW_TMR_W-1:0] WDT_CYC_0 =
    `SRW_TMR_W'(int'(`SRW_WDT_T0_S * `SRW_CLK_HZ)),
  parameter logic [`SRW_TMR_W-1:0] WDT_CYC_1 =
    `SRW_TMR_W'(`SRW_WDT_T1_MS * `SRW_CYC_PER_MS),
  parameter logic [`SRW_TMR_W-1:0] WDT_CYC_2 =
    `SRW_TMR_W'(`SRW_WDT_T2_MS * `SRW_CYC_PER_MS),
  parameter logic [`SRW_TMR_W-1:0] HOLD_CYC_LONG =
    `SRW_TMR_W'(`SRW_HOLD_LONG_MS * `SRW_CYC_PER_MS),
  parameter logic [`SRW_TMR_W-1:0] HOLD_CYC_SHORT =
    `SRW_TMR_W'(`SRW_HOLD_SHORT_MS * `SRW_CYC_PER_MS),
  parameter logic [`SRW_TMR_W-1:0] NVM_CYC =
    `SRW_TMR_W'(`SRW_NVM_WC_TYP_MS * `SRW_CYC_PER_MS)
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`SRW_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  main_supply_ok,
  input  wire logic                  second_supply_ok,
  input  wire logic                  third_supply_ok,
  input  wire logic                  manual_reset_in_n,
  input  wire logic                  wdt_restart_in,
  input  wire logic                  nv_write_stop,
  output logic                       reset_out_n,
  output logic                       low_supply_warn,
  output logic                       watchdog_expired_n,
  output logic                       second_supply_fail_n,
  output logic                       third_supply_fail_n,
  output logic                       nvm_write_busy,
  output logic                       irq
);

  //////////////////////////////////////////////////////////////////////
  // pin synchronisation and edges

  logic [4:0] pin_s;
  logic       sup_ok;
  logic       v2_ok;
  logic       v3_ok;
  logic       man_act;
  logic       restart_lvl;
  logic       restart_d;
  logic       restart_pulse;
  logic       sup_d;
  logic       v2_d;
  logic       v3_d;

  srw_sync #(.W(5)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({wdt_restart_in, ~manual_reset_in_n, third_supply_ok,
               second_supply_ok, main_supply_ok}),
    .q       (pin_s)
  );

  assign sup_ok      = pin_s[0];
  assign v2_ok       = pin_s[1];
  assign v3_ok       = pin_s[2];
  assign man_act     = pin_s[3];
  assign restart_lvl = pin_s[4];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_d <= 1'b0;
      sup_d     <= 1'b0;
      v2_d      <= 1'b0;
      v3_d      <= 1'b0;
    end else begin
      restart_d <= restart_lvl;
      sup_d     <= sup_ok;
      v2_d      <= v2_ok;
      v3_d      <= v3_ok;
    end
  end

  // width of the pulse is the host's job; any rising edge restarts
  // restart edge
  assign restart_pulse = restart_lvl && !restart_d;

  //////////////////////////////////////////////////////////////////////
  // registers and apb slave

  srw_pkg::srw_ctrl_t  ctrl;
  srw_pkg::srw_irq_t   int_stat;
  srw_pkg::srw_irq_t   int_mask;
  srw_pkg::srw_irq_t   ev;
  srw_pkg::srw_state_t state;
  logic [31:0]         rd_val;
  logic [31:0]         status_val;
  logic                setup;
  logic                wr;
  srw_pkg::srw_reg_t   wsel;

  function automatic srw_pkg::srw_reg_t reg_sel(
    input logic [`SRW_ADDR_W-1:0] a
  );
    case (a)
      `SRW_OFF_CTRL:     reg_sel = srw_pkg::SRW_REG_CTRL;
      `SRW_OFF_STATUS:   reg_sel = srw_pkg::SRW_REG_STATUS;
      `SRW_OFF_INT_STAT: reg_sel = srw_pkg::SRW_REG_ISTAT;
      `SRW_OFF_INT_MASK: reg_sel = srw_pkg::SRW_REG_IMASK;
      default:           reg_sel = srw_pkg::SRW_REG_NONE;
    endcase
  endfunction

  assign setup = psel && !penable;
  assign wsel  = reg_sel(paddr);
  assign wr    = psel && penable && pready && pwrite && !pslverr;

  assign status_val = {23'h0, nvm_write_busy, third_supply_fail_n,
                       second_supply_fail_n, watchdog_expired_n,
                       low_supply_warn, reset_out_n, state};

  always_comb begin
    case (wsel)
      srw_pkg::SRW_REG_CTRL:   rd_val = {28'h0, ctrl};
      srw_pkg::SRW_REG_STATUS: rd_val = status_val;
      srw_pkg::SRW_REG_ISTAT:  rd_val = {26'h0, int_stat};
      srw_pkg::SRW_REG_IMASK:  rd_val = {26'h0, int_mask};
      default:                 rd_val = 32'h0;
    endcase
  end

  // one wait-free access phase: answer is registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && wsel == srw_pkg::SRW_REG_NONE;
      prdata  <= (setup && !pwrite) ? rd_val : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= `SRW_CTRL_RST;
      int_mask <= '0;
    end else if (wr) begin
      if (wsel == srw_pkg::SRW_REG_CTRL)
        ctrl <= pwdata[`SRW_CTRL_W-1:0];
      if (wsel == srw_pkg::SRW_REG_IMASK)
        int_mask <= pwdata[`SRW_IRQ_W-1:0];
    end
  end

  // a new event beats a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= '0;
    end else if (wr && wsel == srw_pkg::SRW_REG_ISTAT) begin
      int_stat <= (int_stat & ~pwdata[`SRW_IRQ_W-1:0]) | ev;
    end else begin
      int_stat <= int_stat | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(int_stat & int_mask);
  end

  //////////////////////////////////////////////////////////////////////
  // period selection

  logic       wdt_en;
  logic [1:0] por_sel;
  logic [1:0] wdt_sel;

  assign por_sel = {ctrl.por_delay_sel_hi, ctrl.por_delay_sel_lo};
  assign wdt_sel = {ctrl.wdt_period_sel_hi, ctrl.wdt_period_sel_lo};
  assign wdt_en  = wdt_sel != 2'h3;

  function automatic logic [`SRW_TMR_W-1:0] por_len(input logic [1:0] s);
    case (s)
      2'h0:    por_len = POR_CYC_0;
      2'h1:    por_len = POR_CYC_1;
      2'h2:    por_len = POR_CYC_2;
      default: por_len = POR_CYC_3;
    endcase
  endfunction

  function automatic logic [`SRW_TMR_W-1:0] wdt_len(input logic [1:0] s);
    case (s)
      2'h0:    wdt_len = WDT_CYC_0;
      2'h1:    wdt_len = WDT_CYC_1;
      default: wdt_len = WDT_CYC_2;
    endcase
  endfunction

  function automatic logic [`SRW_TMR_W-1:0] hold_len(input logic [1:0] s);
    case (s)
      2'h2:    hold_len = HOLD_CYC_SHORT;
      default: hold_len = HOLD_CYC_LONG;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////
  // timers

  logic por_exp;
  logic wdt_exp;
  logic hold_exp;
  logic lr_exp;
  logic nvm_exp;
  logic nvm_busy;
  logic nvm_start;
  logic sup_fall;

  assign sup_fall  = sup_d && !sup_ok;
  // a stop while busy is ignored; the host polls or waits
  assign nvm_start = nv_write_stop && !nvm_busy;

  // count only while in power-on hold
  srw_timer u_por (
    .pclk (pclk), .presetn (presetn),
    .load (state != srw_pkg::SRW_ST_POR),
    .run  (state == srw_pkg::SRW_ST_POR),
    .len  (por_len(por_sel)), .expire (por_exp), .busy ()
  );

  // reload on restart, on leaving run, and after expiry
  srw_timer u_wdt (
    .pclk (pclk), .presetn (presetn),
    .load (state != srw_pkg::SRW_ST_RUN || restart_pulse || !wdt_en),
    .run  (state == srw_pkg::SRW_ST_RUN && wdt_en),
    .len  (wdt_len(wdt_sel)), .expire (wdt_exp), .busy ()
  );

  srw_timer u_hold (
    .pclk (pclk), .presetn (presetn),
    .load (state != srw_pkg::SRW_ST_WDT),
    .run  (state == srw_pkg::SRW_ST_WDT),
    .len  (hold_len(wdt_sel)), .expire (hold_exp), .busy ()
  );

  srw_timer u_lr (
    .pclk (pclk), .presetn (presetn),
    .load (sup_fall), .run (1'b1),
    .len  (`SRW_TMR_W'(`SRW_LR_CYC)), .expire (lr_exp), .busy ()
  );

  // self-timed write, typical figure, under the maximum
  srw_timer u_nvm (
    .pclk (pclk), .presetn (presetn),
    .load (nvm_start), .run (1'b1),
    .len  (NVM_CYC), .expire (nvm_exp), .busy (nvm_busy)
  );

  //////////////////////////////////////////////////////////////////////
  // manual reset qualification

  logic [`SRW_MAN_CNT_W-1:0] man_cnt;
  logic                      man_ok;

  // accepted after 5 us held; shorter pulses are lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      man_cnt <= '0;
    else if (!man_act)
      man_cnt <= '0;
    else if (man_cnt != `SRW_MAN_CNT_W'(`SRW_MAN_QUAL_CYC))
      man_cnt <= man_cnt + `SRW_MAN_CNT_W'(1);
  end

  assign man_ok = man_cnt == `SRW_MAN_CNT_W'(`SRW_MAN_QUAL_CYC);

  //////////////////////////////////////////////////////////////////////
  // reset sequencing

  logic lr_fired;

  // supply loss outranks manual reset, which outranks the watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= srw_pkg::SRW_ST_LOW;
    end else if (!sup_ok) begin
      state <= srw_pkg::SRW_ST_LOW;
    end else if (man_ok) begin
      state <= srw_pkg::SRW_ST_MANUAL;
    end else begin
      case (state)
        srw_pkg::SRW_ST_LOW: begin
          state <= srw_pkg::SRW_ST_POR;
        end
        srw_pkg::SRW_ST_MANUAL: begin
          state <= srw_pkg::SRW_ST_POR;
        end
        // leave hold for run only on elapsed delay
        srw_pkg::SRW_ST_POR: begin
          if (por_exp)
            state <= srw_pkg::SRW_ST_RUN;
        end
        srw_pkg::SRW_ST_RUN: begin
          if (wdt_exp)
            state <= srw_pkg::SRW_ST_WDT;
        end
        srw_pkg::SRW_ST_WDT: begin
          if (hold_exp)
            state <= srw_pkg::SRW_ST_RUN;
        end
        default: begin
          state <= srw_pkg::SRW_ST_LOW;
        end
      endcase
    end
  end

  // reset already held in any non-run state stays held on power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lr_fired <= 1'b1;
    else if (lr_exp || (state != srw_pkg::SRW_ST_RUN &&
                        state != srw_pkg::SRW_ST_LOW))
      lr_fired <= 1'b1;
    else if (state == srw_pkg::SRW_ST_RUN)
      lr_fired <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // events and outputs

  always_comb begin
    ev              = '0;
    ev.wdt_timeout  = wdt_exp;
    ev.manual_reset = man_act &&
      man_cnt == `SRW_MAN_CNT_W'(`SRW_MAN_QUAL_CYC - 1);
    ev.supply_low   = sup_fall;
    ev.second_fail  = v2_d && !v2_ok;
    ev.third_fail   = v3_d && !v3_ok;
    ev.nvm_done     = nvm_exp;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_out_n          <= 1'b0;
      low_supply_warn      <= 1'b1;
      watchdog_expired_n   <= 1'b1;
      second_supply_fail_n <= 1'b0;
      third_supply_fail_n  <= 1'b0;
      nvm_write_busy       <= 1'b0;
    end else begin
      // warning first, reset after the gap
      low_supply_warn      <= !sup_ok;
      reset_out_n          <= state == srw_pkg::SRW_ST_RUN ||
                              (state == srw_pkg::SRW_ST_LOW && !lr_fired);
      // watchdog output low through the hold
      watchdog_expired_n   <= state != srw_pkg::SRW_ST_WDT;
      second_supply_fail_n <= v2_ok;
      third_supply_fail_n  <= v3_ok;
      nvm_write_busy       <= nvm_start || (nvm_busy && !nvm_exp);
    end
  end

endmodule

// [dv/srw_supervisor_monitor.sv]
/*
  Checker of supervisor port timing, bound into srw_supervisor.
  Assumes the shortened counts are handed on by the bind.
*/
`timescale 1ns/1ps

module srw_supervisor_monitor #(
  parameter int HOLD_CYC_LONG  = 50,
  parameter int HOLD_CYC_SHORT = 20,
  parameter int POR_CYC_0      = 40,
  parameter int NVM_CYC        = 30
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        main_supply_ok,
  input wire logic        manual_reset_in_n,
  input wire logic        nv_write_stop,
  input wire logic        reset_out_n,
  input wire logic        low_supply_warn,
  input wire logic        watchdog_expired_n,
  input wire logic        nvm_write_busy
);
  localparam int NVM_LO = NVM_CYC - 1;
  localparam int NVM_HI = 2 * NVM_CYC;
  logic [1:0]  wdt_sel;
  logic [9:0]  man_cnt;
  logic [27:0] ok_cnt;
  logic [27:0] lo_cnt;
  int          hold_lo;
  int          hold_hi;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_sel <= 2'h3;
    end else if (psel && penable && pready && pwrite && !pslverr &&
                 paddr == 12'h000) begin
      wdt_sel <= pwdata[3:2];
    end
  end

  // saturating, so a long press never wraps below the qualify time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      man_cnt <= 10'h000;
      ok_cnt  <= 28'h0;
      lo_cnt  <= 28'h0;
    end else begin
      man_cnt <= manual_reset_in_n ? 10'h000
                                   : man_cnt + 10'(man_cnt != 10'h3FF);
      ok_cnt <= (main_supply_ok && manual_reset_in_n) ? ok_cnt + 28'h1
                                                      : 28'h0;
      lo_cnt <= watchdog_expired_n ? 28'h0 : lo_cnt + 28'h1;
    end
  end

  // hold window is half to one and a half of the typical figure
  assign hold_lo = (wdt_sel == 2'h2) ? HOLD_CYC_SHORT / 2
                                     : HOLD_CYC_LONG / 2;
  assign hold_hi = (wdt_sel == 2'h2) ? HOLD_CYC_SHORT * 3 / 2
                                     : HOLD_CYC_LONG * 3 / 2;

  ////////////////////////////////////////////////////////////////////
  sequence s_warn_up;
    $rose(low_supply_warn) && reset_out_n;
  endsequence
  sequence s_gap;
    reset_out_n [*8];
  endsequence

  a_apb_zero_wait: assert property (psel && !penable |=> pready)
    else $error("access cycle without ready");
  a_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("error response outside access cycle");
  a_warn_leads_reset: assert property (
    s_warn_up |-> s_gap ##[1:492] !reset_out_n)
    else $error("warning not ahead of reset");
  a_supply_reset_bound: assert property (
    $fell(main_supply_ok) |-> ##[1:500] !reset_out_n)
    else $error("reset late after supply fall");
  a_manual_qualified: assert property (
    $fell(reset_out_n) && watchdog_expired_n && !low_supply_warn
    |-> man_cnt >= 10'h1F4)
    else $error("manual reset taken too early");
  a_hold_forces_reset: assert property (
    !watchdog_expired_n |-> !reset_out_n)
    else $error("watchdog hold without reset");
  a_wdt_hold_window: assert property (
    $rose(watchdog_expired_n) |-> lo_cnt >= hold_lo && lo_cnt <= hold_hi)
    else $error("watchdog hold length out of window");
  a_por_elapsed: assert property (
    $rose(reset_out_n) && $past(watchdog_expired_n) |-> ok_cnt >= POR_CYC_0)
    else $error("reset released before power-on delay");
  a_nvm_starts: assert property (
    nv_write_stop && !nvm_write_busy |=> nvm_write_busy)
    else $error("write cycle not started");
  a_nvm_duration: assert property (
    $rose(nvm_write_busy) |-> ##[NVM_LO:NVM_HI] $fell(nvm_write_busy))
    else $error("write cycle length wrong");
endmodule

bind srw_supervisor srw_supervisor_monitor #(
  .HOLD_CYC_LONG  (HOLD_CYC_LONG),
  .HOLD_CYC_SHORT (HOLD_CYC_SHORT),
  .POR_CYC_0      (POR_CYC_0),
  .NVM_CYC        (NVM_CYC)
) srw_supervisor_monitor_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .main_supply_ok, .manual_reset_in_n, .nv_write_stop,
  .reset_out_n, .low_supply_warn, .watchdog_expired_n, .nvm_write_busy
);

// [dv/srw_host_model.sv]
/*
  Host side: watchdog restart pulses and write-ending stops.
  Assumes pclk at 100 MHz; tasks are called by the bench.
*/
`timescale 1ns/1ps

module srw_host_model (
  input  wire logic pclk,
  input  wire logic nvm_write_busy,
  output logic      wdt_restart_in,
  output logic      nv_write_stop
);
  initial begin
    wdt_restart_in = 1'b0;
    nv_write_stop = 1'b0;
  end

  task automatic restart();
    @(posedge pclk);
    wdt_restart_in <= 1'b1;
    repeat (100) @(posedge pclk);
    wdt_restart_in <= 1'b0;
  endtask

  task automatic nv_write(output int cyc);
    @(posedge pclk);
    nv_write_stop <= 1'b1;
    @(posedge pclk);
    nv_write_stop <= 1'b0;
    cyc = 0;
    do begin
      @(negedge pclk);
      cyc++;
    end while (nvm_write_busy !== 1'b0 && cyc < 5000);
  endtask
endmodule

// [dv/srw_supervisor_test.sv]
/*
  Self-checking bench of the supervisor over APB and its pins.
  Assumes shortened counts and the host model for restarts and writes.
*/
`timescale 1ns/1ps

module srw_supervisor_test;
  localparam int PORC [4] = '{40, 60, 80, 100};
  localparam int WDTC [3] = '{300, 200, 120};
  localparam int HOLDC [3] = '{50, 50, 20};
  localparam int NVM = 30;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        main_supply_ok;
  logic        second_supply_ok;
  logic        third_supply_ok;
  logic        manual_reset_in_n;
  logic        wdt_restart_in;
  logic        nv_write_stop;
  logic        reset_out_n;
  logic        low_supply_warn;
  logic        watchdog_expired_n;
  logic        second_supply_fail_n;
  logic        third_supply_fail_n;
  logic        nvm_write_busy;
  logic        irq;
  int          err_count = 0;
  int          compares = 0;

  srw_supervisor #(
    .POR_CYC_0 (28'(PORC[0])), .POR_CYC_1 (28'(PORC[1])),
    .POR_CYC_2 (28'(PORC[2])), .POR_CYC_3 (28'(PORC[3])),
    .WDT_CYC_0 (28'(WDTC[0])), .WDT_CYC_1 (28'(WDTC[1])),
    .WDT_CYC_2 (28'(WDTC[2])), .HOLD_CYC_LONG (28'(HOLDC[0])),
    .HOLD_CYC_SHORT (28'(HOLDC[2])), .NVM_CYC (28'(NVM))
  ) srw_supervisor_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .main_supply_ok, .second_supply_ok,
    .third_supply_ok, .manual_reset_in_n, .wdt_restart_in, .nv_write_stop,
    .reset_out_n, .low_supply_warn, .watchdog_expired_n,
    .second_supply_fail_n, .third_supply_fail_n, .nvm_write_busy, .irq
  );
  srw_host_model srw_host_model_i (
    .pclk, .nvm_write_busy, .wdt_restart_in, .nv_write_stop
  );

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {main_supply_ok, second_supply_ok, third_supply_ok} = 3'h7;
    manual_reset_in_n = 1'b1;
  end
  always #5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic inr(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h1);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; the 30000-cycle run limit ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return reset_out_n;
      1: return low_supply_warn;
      default: return watchdog_expired_n;
    endcase
  endfunction
  task automatic wait_for(input int w, input logic lvl, output int n);
    n = 0;
    while (pick(w) !== lvl && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    chk(32'(pick(w)), 32'(lvl));
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    $display("MISMATCH %0t run did not finish", $time);
    summarize();
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic        e;
    int          n;
    int          m;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_for(0, 1'b1, n);
    inr(n, PORC[1], PORC[1] + 10);
    apb(1'b0, 12'h000, 32'h0, q, e);
    chk(q, 32'hD);
    apb(1'b0, 12'h00C, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b1, 12'h004, 32'hFFFFFFFF, q, e);
    chk(32'(e), 32'h0);
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk(32'(e), 32'h1);
    repeat (350) @(negedge pclk);
    chk(32'(watchdog_expired_n), 32'h1);
    $display("registers and idle watchdog done");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 12'h000, 32'hC + 32'(s), q, e);
      manual_reset_in_n <= 1'b0;
      wait_for(0, 1'b0, n);
      inr(n, 500, 510);
      repeat (20) @(posedge pclk);
      manual_reset_in_n <= 1'b1;
      wait_for(0, 1'b1, n);
      inr(n, PORC[s], PORC[s] + 10);
    end
    @(posedge pclk);
    manual_reset_in_n <= 1'b0;
    repeat (300) @(posedge pclk);
    manual_reset_in_n <= 1'b1;
    repeat (10) @(negedge pclk);
    chk(32'(reset_out_n), 32'h1);
    chk(32'(irq), 32'h0);
    apb(1'b1, 12'h00C, 32'h2, q, e);
    repeat (2) @(negedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, 12'h008, 32'h2, q, e);
    repeat (2) @(negedge pclk);
    chk(32'(irq), 32'h0);
    $display("manual reset and interrupt done");
    @(posedge pclk);
    {main_supply_ok, second_supply_ok, third_supply_ok} <= 3'h0;
    wait_for(1, 1'b1, n);
    wait_for(0, 1'b0, m);
    inr(n + m, 1, 500);
    inr(m, 45, 55);
    chk(32'({second_supply_fail_n, third_supply_fail_n}), 32'h0);
    @(posedge pclk);
    {main_supply_ok, second_supply_ok, third_supply_ok} <= 3'h7;
    wait_for(0, 1'b1, n);
    inr(n, PORC[3], PORC[3] + 10);
    chk(32'({second_supply_fail_n, third_supply_fail_n}), 32'h3);
    srw_host_model_i.nv_write(n);
    inr(n, NVM, 2 * NVM);
    apb(1'b0, 12'h008, 32'h0, q, e);
    chk(q & 32'h20, 32'h20);
    $display("supply and write cycle done");
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, 12'h000, 32'(s) << 2, q, e);
      fork
        srw_host_model_i.restart();
      join_none
      wait_for(2, 1'b0, n);
      inr(n, WDTC[s], WDTC[s] + 8);
      wait_for(2, 1'b1, n);
      inr(n, HOLDC[s] - 1, HOLDC[s] + 3);
      wait_for(2, 1'b0, n);
      inr(n, WDTC[s] - 2, WDTC[s] + 4);
      wait_for(2, 1'b1, n);
    end
    $display("watchdog done");
    summarize();
  end
endmodule
